// ===== shared/adt_regs.svh
// constants for the analog differential trigger: widths, ranges, resets
// assumes inclusion by bare name from package and design files
`ifndef ADT_REGS_SVH
`define ADT_REGS_SVH
`define ADT_IN_W 16
`define ADT_GAIN_W 12
`define ADT_OFFS_W 16
`define ADT_THR_W 16
`define ADT_ACC_W 32
`define ADT_GAIN_MIN (-1000)
`define ADT_GAIN_MAX 1000
`define ADT_GAIN_SCALE 100
`define ADT_OFFS_MIN (-10000)
`define ADT_OFFS_MAX 10000
`define ADT_THR_MIN (-20000)
`define ADT_THR_MAX 20000
`define ADT_DEC_MAX 3
`define ADT_OUT_RST 1'h0
`endif

// ===== shared/adt_pkg.sv
// types for the analog differential trigger
// assumes adt_regs.svh is on the include path
`include "adt_regs.svh"
package adt_pkg;
  typedef enum logic [0:0] {
    ADT_MODE_HYST = 1'b0,
    ADT_MODE_WIN = 1'b1
  } adt_mode_t;
  typedef struct packed {
    logic trig_out;
    logic signed [`ADT_ACC_W-1:0] scaled;
    logic signed [`ADT_ACC_W-1:0] off_thr;
    adt_mode_t mode;
    logic [1:0] decimals;
    logic cfg_err;
  } adt_state_t;
endpackage : adt_pkg

// ===== hw/adt_trigger.sv
// analog differential trigger: scaled value against on/off thresholds
// assumes all inputs come from logic on clk_sys; no pin synchronisers
`timescale 1ns/1ps
`include "adt_regs.svh"
module adt_trigger
  import adt_pkg::*;
#(
  parameter int IN_W = `ADT_IN_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic eval_en,
  input wire logic signed [IN_W-1:0] analog_input,
  // scaling settings, gain in hundredths
  input wire logic signed [`ADT_GAIN_W-1:0] gain,
  input wire logic signed [`ADT_OFFS_W-1:0] zero_offset,
  // threshold settings and display decimals
  input wire logic signed [`ADT_THR_W-1:0] on_thr,
  input wire logic signed [`ADT_THR_W-1:0] diff_val,
  input wire logic [1:0] decimals,
  // registered results
  output logic trig_out,
  output logic signed [`ADT_ACC_W-1:0] scaled_value,
  output logic signed [`ADT_ACC_W-1:0] off_thr,
  output logic window_mode,
  output logic [1:0] display_decimals,
  output logic cfg_err
);

  adt_state_t st;
  adt_state_t next_st;

  // clamp a setting into its legal signed range
  function automatic logic signed [`ADT_ACC_W-1:0] clamp(
    input logic signed [`ADT_ACC_W-1:0] v,
    input logic signed [`ADT_ACC_W-1:0] lo,
    input logic signed [`ADT_ACC_W-1:0] hi
  );
    logic signed [`ADT_ACC_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp

  function automatic logic in_range(
    input logic signed [`ADT_ACC_W-1:0] v,
    input logic signed [`ADT_ACC_W-1:0] lo,
    input logic signed [`ADT_ACC_W-1:0] hi
  );
    logic lo_ok;
    logic hi_ok;
    lo_ok = (v >= lo);
    hi_ok = (v <= hi);
    return lo_ok && hi_ok;
  endfunction : in_range

  // gain in hundredths, truncating toward zero
  function automatic logic signed [`ADT_ACC_W-1:0] scale_val(
    input logic signed [`ADT_ACC_W-1:0] x,
    input logic signed [`ADT_ACC_W-1:0] g,
    input logic signed [`ADT_ACC_W-1:0] o
  );
    logic signed [`ADT_ACC_W-1:0] p;
    // clamped 16x11 bit product always fits the accumulator
    p = x * g;
    // signed divide keeps the sign of the product
    p = p / `ADT_GAIN_SCALE;
    return p + o;
  endfunction : scale_val

  // band test, on inclusive, off exclusive
  function automatic logic win_hit(
    input logic signed [`ADT_ACC_W-1:0] v,
    input logic signed [`ADT_ACC_W-1:0] on_v,
    input logic signed [`ADT_ACC_W-1:0] off_v
  );
    logic lo_ok;
    logic hi_ok;
    lo_ok = (v >= on_v);
    hi_ok = (v < off_v);
    return lo_ok && hi_ok;
  endfunction : win_hit

  // set above on, clear at or below off, else hold
  function automatic logic hyst_next(
    input logic signed [`ADT_ACC_W-1:0] v,
    input logic signed [`ADT_ACC_W-1:0] on_v,
    input logic signed [`ADT_ACC_W-1:0] off_v,
    input logic prev
  );
    logic r;
    r = prev;
    // set tested first: with zero differential above on wins
    if (v > on_v) begin
      r = 1'h1;
    end else if (v <= off_v) begin
      r = 1'h0;
    end
    return r;
  endfunction : hyst_next

  function automatic adt_mode_t mode_of(
    input logic signed [`ADT_ACC_W-1:0] d
  );
    adt_mode_t m;
    m = ADT_MODE_HYST;
    if (d > 0) begin
      m = ADT_MODE_WIN;
    end
    return m;
  endfunction : mode_of

  // widened copies of the raw settings
  logic signed [`ADT_ACC_W-1:0] g_raw;
  logic signed [`ADT_ACC_W-1:0] o_raw;
  logic signed [`ADT_ACC_W-1:0] on_raw;
  logic signed [`ADT_ACC_W-1:0] d_raw;
  logic signed [`ADT_ACC_W-1:0] x_w;
  // clamped copies used by scaling and every trigger compare; range checks use the raw copies
  logic signed [`ADT_ACC_W-1:0] g_c;
  logic signed [`ADT_ACC_W-1:0] o_c;
  logic signed [`ADT_ACC_W-1:0] on_c;
  logic signed [`ADT_ACC_W-1:0] d_c;
  logic signed [`ADT_ACC_W-1:0] val;
  logic signed [`ADT_ACC_W-1:0] offv;
  logic bad_gain;
  logic bad_offs;
  logic bad_on;
  logic bad_diff;
  logic bad;
  adt_mode_t mode_sel;

  always_comb begin
    next_st = st;
    g_raw = `ADT_ACC_W'(gain);
    o_raw = `ADT_ACC_W'(zero_offset);
    on_raw = `ADT_ACC_W'(on_thr);
    d_raw = `ADT_ACC_W'(diff_val);
    x_w = `ADT_ACC_W'(analog_input);

    bad_gain = !in_range(g_raw, `ADT_GAIN_MIN, `ADT_GAIN_MAX);
    bad_offs = !in_range(o_raw, `ADT_OFFS_MIN, `ADT_OFFS_MAX);
    bad_on = !in_range(on_raw, `ADT_THR_MIN, `ADT_THR_MAX);
    bad_diff = !in_range(d_raw, `ADT_THR_MIN, `ADT_THR_MAX);
    bad = bad_gain || bad_offs || bad_on || bad_diff;

    // clamped so a bad setting stays inside the legal span
    g_c = clamp(g_raw, `ADT_GAIN_MIN, `ADT_GAIN_MAX);
    o_c = clamp(o_raw, `ADT_OFFS_MIN, `ADT_OFFS_MAX);
    on_c = clamp(on_raw, `ADT_THR_MIN, `ADT_THR_MAX);
    d_c = clamp(d_raw, `ADT_THR_MIN, `ADT_THR_MAX);

    // working value from clamped gain and offset
    val = scale_val(x_w, g_c, o_c);
    offv = on_c + d_c;
    mode_sel = mode_of(d_c);

    if (eval_en) begin
      next_st.scaled = val;
      next_st.off_thr = offv;
      next_st.cfg_err = bad;
      next_st.decimals = decimals;
      next_st.mode = mode_sel;
      if (mode_sel == ADT_MODE_WIN) begin
        next_st.trig_out = win_hit(val, on_c, offv);
      end else begin
        next_st.trig_out = hyst_next(val, on_c, offv, st.trig_out);
      end
    end
  end

  // registered once per enabled cycle, reset clears
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st.trig_out <= `ADT_OUT_RST;
      st.scaled <= '0;
      st.off_thr <= '0;
      st.mode <= ADT_MODE_HYST;
      st.decimals <= 2'h0;
      st.cfg_err <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // every output is a bare state field, no logic after the flops
  assign trig_out = st.trig_out;
  assign scaled_value = st.scaled;
  assign off_thr = st.off_thr;
  assign window_mode = st.mode;
  assign display_decimals = st.decimals;
  assign cfg_err = st.cfg_err;

endmodule : adt_trigger

// ===== verif/adt_src.sv
// upstream analog source: hands the chosen sample on
// assumes the bench sets src_val after a clock edge
`timescale 1ns/1ps
module adt_src (
  input wire logic signed [15:0] src_val,
  output logic signed [15:0] analog_input
);
  assign analog_input = src_val;
endmodule : adt_src

// ===== verif/adt_trigger_chk.sv
// checker: trigger outputs against the settings that caused them
// assumes a bind to adt_trigger, one clock domain
`timescale 1ns/1ps
module adt_trigger_chk #(parameter int IN_W = 16) (
  input wire logic clk_sys, nrst, eval_en, trig_out, window_mode, cfg_err,
  input wire logic signed [IN_W-1:0] analog_input,
  input wire logic signed [11:0] gain,
  input wire logic signed [15:0] zero_offset, on_thr, diff_val,
  input wire logic [1:0] decimals, display_decimals,
  input wire logic signed [31:0] scaled_value, off_thr);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_scale_calc: assert property (eval_en |=> cfg_err ||
    scaled_value == $past(analog_input) * $past(gain) / 100
    + $past(zero_offset)) else $error("scaled value wrong");
  a_off_sum: assert property (eval_en |=> cfg_err ||
    off_thr == $past(on_thr) + $past(diff_val)) else $error("off wrong");
  a_win_band: assert property (eval_en && diff_val > 0 |=>
    trig_out == (scaled_value >= $past(on_thr) && scaled_value < off_thr))
    else $error("window output wrong");
  a_hyst_set: assert property (eval_en && diff_val <= 0 |=>
    scaled_value <= $past(on_thr) || trig_out) else $error("no set");
  a_hyst_clear: assert property (eval_en && diff_val <= 0 |=>
    scaled_value > off_thr || !trig_out) else $error("no clear");
  a_hyst_hold: assert property (eval_en && diff_val < 0 |=>
    scaled_value <= off_thr || scaled_value > $past(on_thr) ||
    trig_out == $past(trig_out)) else $error("no hold");
  a_dec_copy: assert property (eval_en |=>
    display_decimals == $past(decimals)) else $error("decimals wrong");
  a_idle_hold: assert property (!eval_en |=>
    $stable(trig_out) && $stable(scaled_value)) else $error("idle change");
  a_gain_range: assert property (eval_en && (gain > 1000 ||
    gain < -1000) |=> cfg_err) else $error("range flag missing");
  cover property (eval_en && diff_val > 0);
  cover property (eval_en && diff_val < 0);
  cover property (cfg_err);
endmodule : adt_trigger_chk

// ===== verif/testbench.sv
// bench: evaluation table against a reference of the trigger
// assumes a one-cycle answer after each enabled edge
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 0, nrst = 0, eval_en = 0, trig_out, window_mode, cfg_err;
  logic signed [15:0] src_val = 0, zero_offset = 0, on_thr = 0, diff_val = 0;
  logic signed [15:0] analog_input;
  logic signed [11:0] gain = 0;
  logic [1:0] decimals = 0, display_decimals;
  logic signed [31:0] scaled_value, off_thr;
  int miscompares = 0, n_checks = 0, s = 0, q = 0;
  always #12.5 clk_sys = ~clk_sys;
  adt_src adt_src_inst (.*);
  adt_trigger adt_trigger_inst (.*);
  task automatic chk(logic [31:0] v, e);
    n_checks++;
    if (v !== e) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, v, e);
    end
  endtask : chk
  task automatic ev(int a, g, o, n, d, p, bit en = 1);
    @(posedge clk_sys);
    {src_val, gain, zero_offset, on_thr, diff_val, decimals, eval_en} <=
      {16'(a), 12'(g), 16'(o), 16'(n), 16'(d), 2'(p), en};
    if (en) s = a * g / 100 + o;
    if (en) q = d > 0 ? (s >= n && s < n + d) :
      s > n ? 1 : s <= n + d ? 0 : q;
    @(posedge clk_sys);
    #1;
    chk(trig_out, q);
    chk(scaled_value, s);
    if (en) begin
      chk(off_thr, n + d);
      chk(window_mode, d > 0);
      chk(display_decimals, p);
      chk(cfg_err, g > 1000 || g < -1000);
    end
  endtask : ev
  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk_sys);
    chk(trig_out, 0);
    nrst <= 1;
    ev(4001, 100, 0, 4000, -2000, 2);
    ev(3000, 100, 0, 4000, -2000, 2);
    ev(2000, 100, 0, 4000, -2000, 2);
    ev(3000, 100, 0, 4000, -2000, 2);
    // truncation toward zero decides this set
    ev(999, -250, 10000, 7502, 0, 1);
    ev(100, 100, 0, 100, 50, 3);
    ev(149, 100, 0, 100, 50, 3);
    ev(150, 100, 0, 100, 50, 3);
    ev(120, 100, 0, 100, 50, 0);
    ev(500, 100, 0, 100, 50, 0, 0);
    ev(0, 1500, 20, 10, -5, 1);
    wrap_up();
  end
endmodule : testbench
bind adt_trigger adt_trigger_chk #(.IN_W(IN_W)) adt_trigger_chk_inst (.*);
